// ===== src/speed_fault_pkg.sv
// shared constants and types for speed sensor fault and output control
package speed_fault_pkg;
    localparam int unsigned CLK_NS = 100;
    // fault level must stand longer than this time
    localparam int unsigned FAULT_HOLD_NS = 1000000;
    localparam int unsigned FAULT_HOLD_CYCLES = FAULT_HOLD_NS / CLK_NS + 1;
    localparam int unsigned HOLD_W = 16;
    localparam int unsigned N_MON = 8;
    localparam int unsigned AMP_W = 12;
    localparam int unsigned PW_W = 12;
    localparam int unsigned RECAL_RATIO_SHIFT = 1;
    localparam int unsigned N_CHAN = 2;

    typedef enum logic [1:0] {
        LVL_LOW = 2'h0,
        LVL_HIGH = 2'h1,
        LVL_FAULT_HIGH = 2'h2,
        LVL_POWER_ON = 2'h3
    } out_level_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_FAULT = 3'h2,
        ST_CTRL_RESET = 3'h4
    } fault_state_t;

    typedef struct packed {
        logic level;
        logic last_req;
        logic busy;
        logic [PW_W-1:0] count;
    } pulse_state_t;

    typedef struct packed {
        fault_state_t state;
        logic [HOLD_W-1:0] hold;
        logic clearable;
        out_level_t out_a;
        out_level_t out_b;
        logic ctrl_reset;
        logic recal;
        logic recal_cond;
    } fault_ctl_t;
endpackage : speed_fault_pkg

// ===== src/speed_pulse_guard.sv
// one output channel with pulse collision suppression
`timescale 1ns/10ps
`default_nettype none
module speed_pulse_guard (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic clear_i,
    input wire logic pulse_mode_i,
    input wire logic level_i,
    input wire logic [speed_fault_pkg::PW_W-1:0] width_i,
    output logic level_o
);
    speed_fault_pkg::pulse_state_t s;
    speed_fault_pkg::pulse_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.last_req = level_i;
        if (clear_i) begin
            next_s = '0;
            next_s.last_req = level_i;
        end else if (!pulse_mode_i) begin
            next_s.level = level_i; // R8
            next_s.busy = 1'b0;
            next_s.count = '0;
        end else if (s.busy) begin
            // requests seen while busy are dropped, not queued
            if (s.count <= 1) begin // R7
                next_s.busy = 1'b0;
                next_s.level = 1'b0;
                next_s.count = '0;
            end else begin
                next_s.count = s.count - 1'b1;
            end
        end else if (level_i != s.last_req && width_i != '0) begin
            next_s.busy = 1'b1;
            next_s.level = 1'b1;
            next_s.count = width_i;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level_o = s.level;

    no_truncate_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R7
        (pulse_mode_i && s.busy && s.count > 1 && !clear_i) |=> (s.level && s.busy))
        else $error("pulse cut short");
    level_pass_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R8
        (!pulse_mode_i && !clear_i) |=> (s.level == $past(level_i) && !s.busy))
        else $error("level not passed outside pulse mode");
endmodule : speed_pulse_guard
`default_nettype wire

// ===== src/speed_fault_ctl.sv
// fault reporting, recalibration trigger and output conditioning
// Summary of operation
// R1: monitors flag defects, calculation errors and bad stimulus as fault events.
// R2: any fault event moves both outputs from protocol signalling to fault level.
// R3: every fault keeps outputs at fault level for a minimum hold period.
// R4: a subset of monitors is marked clearable by controller reset.
// R5: clearable faults pulse the controller reset only after the full hold.
// R6: amplitude far above stored peaks after calibration triggers immediate recalibration.
// R7: during an output pulse, new transitions are suppressed until width completes.
// R8: collision suppression is active only in pulse protocols.
// R9: fault level lasts longer than 1 ms; controller ignores shorter mid excursions.
// R10: internal diagnostic faults drive both channels to the high fault range.
// R11: undervoltage resets the block and shows the power-on level on outputs.
// R12: hold period is a parameterised cycle counter gating the controller reset.
`timescale 1ns/10ps
`default_nettype none
module speed_fault_ctl #(
    parameter int unsigned HOLD_CYCLES = speed_fault_pkg::FAULT_HOLD_CYCLES
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic supply_lockout_threshold_i,
    input wire logic [speed_fault_pkg::N_MON-1:0] monitor_fault_i,
    input wire logic [speed_fault_pkg::N_MON-1:0] clearable_mask_i,
    input wire logic pulse_mode_i,
    input wire logic [speed_fault_pkg::N_CHAN-1:0] chan_level_i,
    input wire logic [speed_fault_pkg::PW_W-1:0] pulse_width_i,
    input wire logic calibrated_i,
    input wire logic [speed_fault_pkg::AMP_W-1:0] amplitude_i,
    input wire logic [speed_fault_pkg::AMP_W-1:0] stored_peak_i,
    output logic [1:0] out_a_o,
    output logic [1:0] out_b_o,
    output logic ctrl_reset_o,
    output logic recal_o
);
    localparam logic [speed_fault_pkg::HOLD_W-1:0] HOLD_LAST = // R9
        speed_fault_pkg::HOLD_W'(HOLD_CYCLES - 1);

    speed_fault_pkg::fault_ctl_t s;
    speed_fault_pkg::fault_ctl_t next_s;
    logic [speed_fault_pkg::N_CHAN-1:0] guarded;
    logic any_fault;
    logic clear_hit;
    logic big_signal;
    logic [speed_fault_pkg::AMP_W:0] peak_limit;

    // channel guards are cleared with the lockout so no pulse survives it
    genvar ch;
    generate
        for (ch = 0; ch < speed_fault_pkg::N_CHAN; ch++) begin : g_chan
            speed_pulse_guard u_guard (
                .clock_i(clock_i),
                .resetn_i(resetn_i),
                .clear_i(supply_lockout_threshold_i),
                .pulse_mode_i(pulse_mode_i),
                .level_i(chan_level_i[ch]),
                .width_i(pulse_width_i),
                .level_o(guarded[ch])
            );
        end
    endgenerate

    assign any_fault = |monitor_fault_i; // R1
    assign clear_hit = |(monitor_fault_i & clearable_mask_i); // R4
    assign peak_limit = {1'b0, stored_peak_i} << speed_fault_pkg::RECAL_RATIO_SHIFT;
    assign big_signal = calibrated_i && ({1'b0, amplitude_i} > peak_limit);

    always_comb begin
        next_s = s;
        next_s.ctrl_reset = 1'b0;
        next_s.recal = 1'b0;
        next_s.recal_cond = big_signal;
        // one request per excursion, not one per cycle
        if (big_signal && !s.recal_cond) begin
            next_s.recal = 1'b1; // R6
        end
        case (s.state)
            speed_fault_pkg::ST_RUN: begin
                if (any_fault) begin
                    next_s.state = speed_fault_pkg::ST_FAULT; // R2
                    next_s.hold = '0;
                    next_s.clearable = clear_hit;
                end
            end
            speed_fault_pkg::ST_FAULT: begin
                // a clearable hit late in the hold is still honoured
                next_s.clearable = s.clearable | clear_hit;
                if (s.hold != HOLD_LAST) begin
                    next_s.hold = s.hold + 1'b1; // R12
                end else if (s.clearable | clear_hit) begin
                    next_s.state = speed_fault_pkg::ST_CTRL_RESET; // R5
                    next_s.ctrl_reset = 1'b1;
                end else if (!any_fault) begin
                    next_s.state = speed_fault_pkg::ST_RUN; // R3
                end
            end
            speed_fault_pkg::ST_CTRL_RESET: begin
                next_s.clearable = 1'b0;
                next_s.hold = '0;
                next_s.state = speed_fault_pkg::ST_RUN;
            end
            default: begin
                next_s.state = speed_fault_pkg::ST_RUN;
            end
        endcase
        if (next_s.state == speed_fault_pkg::ST_RUN) begin
            next_s.out_a = guarded[0] ? speed_fault_pkg::LVL_HIGH : speed_fault_pkg::LVL_LOW;
            next_s.out_b = guarded[1] ? speed_fault_pkg::LVL_HIGH : speed_fault_pkg::LVL_LOW;
        end else begin
            next_s.out_a = speed_fault_pkg::LVL_FAULT_HIGH; // R10
            next_s.out_b = speed_fault_pkg::LVL_FAULT_HIGH; // R10
        end
        if (supply_lockout_threshold_i) begin
            next_s = '0; // R11
            next_s.state = speed_fault_pkg::ST_RUN;
            next_s.out_a = speed_fault_pkg::LVL_POWER_ON;
            next_s.out_b = speed_fault_pkg::LVL_POWER_ON;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
            s.state <= speed_fault_pkg::ST_RUN;
            s.out_a <= speed_fault_pkg::LVL_POWER_ON;
            s.out_b <= speed_fault_pkg::LVL_POWER_ON;
        end else begin
            s <= next_s;
        end
    end

    assign out_a_o = s.out_a;
    assign out_b_o = s.out_b;
    assign ctrl_reset_o = s.ctrl_reset;
    assign recal_o = s.recal;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    fault_entry_a: assert property ( // R1
        (s.state == speed_fault_pkg::ST_RUN && any_fault && !supply_lockout_threshold_i)
        |=> s.state == speed_fault_pkg::ST_FAULT)
        else $error("fault event not taken");
    both_fault_high_a: assert property ( // R2
        (s.state != speed_fault_pkg::ST_RUN) |->
        (s.out_a == speed_fault_pkg::LVL_FAULT_HIGH && s.out_b == speed_fault_pkg::LVL_FAULT_HIGH))
        else $error("outputs not at fault level");
    hold_stays_a: assert property ( // R3
        (s.state == speed_fault_pkg::ST_FAULT && s.hold != HOLD_LAST
         && !supply_lockout_threshold_i) |=> s.state == speed_fault_pkg::ST_FAULT)
        else $error("fault left before hold end");
    reset_clearable_a: assert property ( // R4
        s.ctrl_reset |-> $past(s.clearable | clear_hit))
        else $error("controller reset without clearable fault");
    reset_after_hold_a: assert property ( // R5
        s.ctrl_reset |-> ($past(s.hold) == HOLD_LAST && !$past(s.ctrl_reset)))
        else $error("controller reset before hold end");
    recal_on_big_a: assert property ( // R6
        (big_signal && !s.recal_cond && !supply_lockout_threshold_i) |=> s.recal)
        else $error("recalibration not requested");
    hold_counts_a: assert property ( // R12
        (s.state == speed_fault_pkg::ST_FAULT && s.hold != HOLD_LAST
         && !supply_lockout_threshold_i) |=> s.hold == $past(s.hold) + 1'b1)
        else $error("hold counter stalled");
    lockout_pos_a: assert property ( // R11
        supply_lockout_threshold_i |=>
        (s.out_a == speed_fault_pkg::LVL_POWER_ON && s.state == speed_fault_pkg::ST_RUN
         && !s.ctrl_reset))
        else $error("lockout did not restore power-on level");
    lockout_out_b_a: assert property ( // R11
        supply_lockout_threshold_i |=> s.out_b == speed_fault_pkg::LVL_POWER_ON)
        else $error("lockout left channel b out of power-on level");
    lockout_quiet_a: assert property ( // R11
        supply_lockout_threshold_i |=> (!s.recal && s.hold == '0 && !s.clearable))
        else $error("lockout left state behind");
    guard_cleared_a: assert property ( // R11
        supply_lockout_threshold_i |=> guarded == '0)
        else $error("pulse survived the lockout");
    // lockout overrides every state, so the checks below leave it out
    sticky_stays_a: assert property ( // R4
        (s.state == speed_fault_pkg::ST_FAULT && !s.clearable && !clear_hit && any_fault
         && !supply_lockout_threshold_i) |=> s.state == speed_fault_pkg::ST_FAULT)
        else $error("sticky fault left while monitors high");
    fault_exit_a: assert property ( // R3
        (s.state == speed_fault_pkg::ST_FAULT && s.hold == HOLD_LAST && !s.clearable
         && !any_fault && !supply_lockout_threshold_i) |=> s.state == speed_fault_pkg::ST_RUN)
        else $error("fault level kept after monitors cleared");
    reset_entry_a: assert property ( // R5
        (s.state == speed_fault_pkg::ST_FAULT && s.hold == HOLD_LAST
         && (s.clearable | clear_hit) && !supply_lockout_threshold_i)
        |=> (s.ctrl_reset && s.state == speed_fault_pkg::ST_CTRL_RESET))
        else $error("controller reset missing after hold");
    reset_single_a: assert property ( // R5
        s.ctrl_reset |=> (!s.ctrl_reset && s.state == speed_fault_pkg::ST_RUN))
        else $error("controller reset longer than one cycle");
    reset_fault_level_a: assert property ( // R3
        s.ctrl_reset |-> (s.out_a == speed_fault_pkg::LVL_FAULT_HIGH
        && s.out_b == speed_fault_pkg::LVL_FAULT_HIGH))
        else $error("fault level dropped during controller reset");
    run_follows_a: assert property ( // R2
        (s.state == speed_fault_pkg::ST_RUN && !any_fault && !supply_lockout_threshold_i) |=>
        (s.out_a == ($past(guarded[0]) ? speed_fault_pkg::LVL_HIGH : speed_fault_pkg::LVL_LOW)
        && s.out_b == ($past(guarded[1]) ? speed_fault_pkg::LVL_HIGH : speed_fault_pkg::LVL_LOW)))
        else $error("outputs do not follow channels");
    recal_single_a: assert property ( // R6
        s.recal |=> !s.recal)
        else $error("recalibration request repeated");
    recal_calibrated_a: assert property ( // R6
        s.recal |-> $past(calibrated_i))
        else $error("recalibration before calibration");
    hold_restart_a: assert property ( // R12
        (s.state == speed_fault_pkg::ST_RUN && any_fault && !supply_lockout_threshold_i)
        |=> s.hold == '0)
        else $error("hold counter not restarted");

    fault_seen_c: cover property (s.state == speed_fault_pkg::ST_FAULT
        ##1 s.state == speed_fault_pkg::ST_FAULT);
    ctrl_reset_c: cover property (s.ctrl_reset);
    recal_c: cover property (s.recal);
    // sticky fault outlasting its hold, and a lockout cutting a hold short
    sticky_fault_c: cover property (s.state == speed_fault_pkg::ST_FAULT && s.hold == HOLD_LAST
        && !s.clearable && any_fault);
    lockout_fault_c: cover property (supply_lockout_threshold_i
        && s.state == speed_fault_pkg::ST_FAULT);
endmodule : speed_fault_ctl
`default_nettype wire

// ===== testbench/speed_fault_monitor_model.sv
// system controller model watching both sensor outputs for a held fault level
`timescale 1ns/10ps
`default_nettype none
module speed_fault_monitor_model #(
    parameter int unsigned HOLD_CYCLES = 8
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic clear_i,
    input wire logic [1:0] out_a_i,
    input wire logic [1:0] out_b_i,
    output logic fault_seen_o
);
    int unsigned run;
    logic both_fault;
    assign both_fault = (out_a_i == speed_fault_pkg::LVL_FAULT_HIGH)
        && (out_b_i == speed_fault_pkg::LVL_FAULT_HIGH);
    // short trips through the fault range are normal edges, only a full hold is a fault
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run <= 0;
            fault_seen_o <= 1'b0;
        end else begin
            if (both_fault) run <= run + 1;
            else run <= 0;
            if (clear_i) fault_seen_o <= 1'b0;
            else if (both_fault && run + 1 >= HOLD_CYCLES) fault_seen_o <= 1'b1;
        end
    end
endmodule : speed_fault_monitor_model
`default_nettype wire

// ===== testbench/speed_fault_ctl_tb_top.sv
// self-checking bench for the fault and output control block
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module speed_fault_ctl_tb_top;
    localparam int unsigned HOLD = 8;
    localparam logic [1:0] FH = speed_fault_pkg::LVL_FAULT_HIGH;
    localparam logic [1:0] LO = speed_fault_pkg::LVL_LOW;
    localparam logic [1:0] HI = speed_fault_pkg::LVL_HIGH;
    localparam logic [1:0] PO = speed_fault_pkg::LVL_POWER_ON;
    logic clock = 1'b0, resetn = 1'b0, lockout = 1'b0, pmode = 1'b0, cal = 1'b0, clr = 1'b0;
    logic [7:0] mon = 8'h00, mask = 8'h00;
    logic [1:0] chan = 2'h0, out_a, out_b;
    logic [11:0] width = 12'h004, amp = 12'h000, peak = 12'h000;
    logic ctrl_reset, recal, seen;
    int mismatches = 0, compares = 0;
    always #50 clock = ~clock;
    speed_fault_ctl #(.HOLD_CYCLES(HOLD)) u_speed_fault_ctl (.clock_i(clock), .resetn_i(resetn),
        .supply_lockout_threshold_i(lockout), .monitor_fault_i(mon), .clearable_mask_i(mask),
        .pulse_mode_i(pmode), .chan_level_i(chan), .pulse_width_i(width), .calibrated_i(cal),
        .amplitude_i(amp), .stored_peak_i(peak), .out_a_o(out_a), .out_b_o(out_b),
        .ctrl_reset_o(ctrl_reset), .recal_o(recal));
    speed_fault_monitor_model #(.HOLD_CYCLES(HOLD)) u_speed_fault_monitor_model (.clock_i(clock),
        .resetn_i(resetn), .clear_i(clr), .out_a_i(out_a), .out_b_i(out_b), .fault_seen_o(seen));
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic fault_clearable();
        mask = 8'h01;
        mon = 8'h01;
        tick(1);
        mon = 8'h00;
        for (int i = 0; i < HOLD; i++) begin
            `CHECK("out_a hold", FH, out_a)
            `CHECK("out_b hold", FH, out_b)
            `CHECK("ctrl_reset early", 1'b0, ctrl_reset)
            tick(1);
        end
        `CHECK("ctrl_reset", 1'b1, ctrl_reset)
        `CHECK("out_a last", FH, out_a)
        tick(1);
        `CHECK("ctrl_reset end", 1'b0, ctrl_reset)
        `CHECK("fault seen", 1'b1, seen)
        clr = 1'b1;
        tick(3);
        clr = 1'b0;
        `CHECK("out_a resumed", LO, out_a)
    endtask : fault_clearable
    task automatic fault_sticky();
        mask = 8'h00;
        mon = 8'h80;
        tick(1);
        for (int i = 0; i < HOLD + 4; i++) begin
            `CHECK("out_b sticky", FH, out_b)
            `CHECK("no ctrl_reset", 1'b0, ctrl_reset)
            tick(1);
        end
        mon = 8'h00;
        tick(4);
        `CHECK("out_b resumed", LO, out_b)
        `CHECK("sticky fault seen", 1'b1, seen)
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
    endtask : fault_sticky
    task automatic recal_trigger();
        cal = 1'b1;
        peak = 12'h100;
        amp = 12'h200;
        tick(2);
        `CHECK("recal at ratio", 1'b0, recal)
        amp = 12'h201;
        tick(1);
        `CHECK("recal pulse", 1'b1, recal)
        tick(1);
        `CHECK("recal single", 1'b0, recal)
        cal = 1'b0;
        tick(1);
    endtask : recal_trigger
    task automatic level_follow();
        chan = 2'h1;
        tick(2);
        `CHECK("out_a level", HI, out_a)
        `CHECK("out_b level", LO, out_b)
        chan = 2'h2;
        tick(1);
        chan = 2'h0;
        tick(1);
        `CHECK("out_b quick", HI, out_b)
        tick(1);
        `CHECK("out_b back", LO, out_b)
    endtask : level_follow
    task automatic pulse_guard();
        pmode = 1'b1;
        tick(3);
        chan = 2'h1;
        tick(1);
        chan = 2'h0;
        for (int i = 0; i < 4; i++) begin
            tick(1);
            `CHECK("pulse high", HI, out_a)
        end
        tick(1);
        `CHECK("pulse done", LO, out_a)
        pmode = 1'b0;
        tick(6);
    endtask : pulse_guard
    task automatic lockout_mid_fault();
        mask = 8'h01;
        mon = 8'h01;
        tick(2);
        lockout = 1'b1;
        tick(1);
        `CHECK("out_a lockout", PO, out_a)
        `CHECK("out_b lockout", PO, out_b)
        `CHECK("lockout no reset", 1'b0, ctrl_reset)
        `CHECK("short trip ignored", 1'b0, seen)
        lockout = 1'b0;
        mon = 8'h00;
        tick(4);
        `CHECK("out_a after lockout", LO, out_a)
    endtask : lockout_mid_fault
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (16) @(posedge clock);
        #1;
        `CHECK("out_a in reset", PO, out_a)
        `CHECK("out_b in reset", PO, out_b)
        resetn = 1'b1;
        tick(2);
        fault_clearable();
        fault_sticky();
        recal_trigger();
        level_follow();
        pulse_guard();
        lockout_mid_fault();
        give_verdict();
    end
    // whole sequence takes roughly 80 cycles, so this leaves wide margin
    initial begin
        repeat (3000) @(posedge clock);
        mismatches++;
        give_verdict();
    end
endmodule : speed_fault_ctl_tb_top
`default_nettype wire
